// ### omc_pkg.sv
package omc_pkg;
  // reset pseudo-vector address pair
  localparam logic [15:0] OMC_RESET_VEC_HI = 16'hdffe;
  localparam logic [15:0] OMC_RESET_VEC_LO = 16'hdfff;
  // stop mode select field in power_mode_control_2
  localparam logic [1:0] OMC_SEL_DEEP = 2'h1;
  localparam logic [1:0] OMC_SEL_LEGACY3 = 2'h3;
  localparam logic [1:0] OMC_SEL_LIGHT = 2'h0;
  localparam logic [1:0] OMC_SEL_SECOND = 2'h2;
  // debug command classes
  localparam logic [2:0] OMC_CMD_MEM = 3'h0;
  localparam logic [2:0] OMC_CMD_MEM_STAT = 3'h1;
  localparam logic [2:0] OMC_CMD_DBG_REG = 3'h2;
  localparam logic [2:0] OMC_CMD_HALT = 3'h3;
  localparam logic [2:0] OMC_CMD_CPU_REG = 3'h4;
  localparam logic [2:0] OMC_CMD_TRACE = 3'h5;
  localparam logic [2:0] OMC_CMD_GO = 3'h6;
  // operating modes, one-hot
  typedef enum logic [4:0] {
    OMC_ST_RESET = 5'h01,
    OMC_ST_RUN = 5'h02,
    OMC_ST_HALT = 5'h04,
    OMC_ST_DEEP = 5'h08,
    OMC_ST_LIGHT = 5'h10
  } omc_state_e;
endpackage

// ### omc_mode_ctrl.sv
`timescale 1ns/1ns
// How it works
// [RULE1] background pin high at reset release: run mode, fetch from reset vector pair
// [RULE2] debug halt on strap low, halt command, enter-debug instruction or breakpoint
// [RULE3] in debug halt the processor stays suspended awaiting debug commands
// [RULE4] non-intrusive commands accepted in both run and debug halt
// [RULE5] register access, trace and resume execute only in debug halt
// [RULE6] stop instruction stops if stop enable set, else illegal-opcode reset
// [RULE7] all clocks halt in stop except the always-running slow oscillator
// [RULE8] stop mode chosen by power_mode_control_2; second stop mode unavailable
// [RULE9] deep stop powers off regulated circuits; exits on reset or interrupt
// [RULE10] deep stop asserts low-voltage detector; exit waits for supply re-arm
// [RULE11] wakeup from deep stop restarts like power-on, taking reset vector
// [RULE12] a pending interrupt at the stop instruction blocks deep stop
// [RULE13] low-voltage trip raises interrupt or reset as configured
// [RULE14] detector plus in-stop enable keep regulator on; deep becomes light stop
// [RULE15] light stop keeps power; cpu, ram, flash standby; pins held
// [RULE16] periodic tick flag sets in run or light stop, not in deep stop
// [RULE17] medium oscillator runs for receiver sampling, measurement or rf sending
// [RULE18] parameter registers, slow oscillator, wakeup timer always powered
// [RULE19] receiver decoder may power detector and medium oscillator in stop
// [RULE20] debug enable turns deep stop into light stop with debug clocks on
// [RULE21] deep stop wakeup resets interface registers and marks ram lost
module omc_mode_ctrl import omc_pkg::*; (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // debug pin strap and halt sources
  input wire logic background_pin_i,
  input wire logic halt_cmd_i,
  input wire logic enter_debug_instr_i,
  input wire logic breakpoint_i,
  // debug command
  input wire logic cmd_valid_i,
  input wire logic [2:0] cmd_class_i,
  // processor events and configuration
  input wire logic stop_instr_i,
  input wire logic stop_enable_i,
  input wire logic [1:0] power_mode_control_2_i,
  input wire logic lowvolt_detect_enable_i,
  input wire logic lowvolt_in_stop_enable_i,
  input wire logic lowvolt_reset_enable_i,
  input wire logic debug_enable_i,
  input wire logic irq_pending_i,
  input wire logic ext_wake_i,
  // analog and sub-block status
  input wire logic supply_low_i,
  input wire logic supply_rearmed_i,
  input wire logic tick_event_i,
  input wire logic tick_on_slow_osc_i,
  input wire logic lfr_sampling_i,
  input wire logic lfr_detect_i,
  input wire logic meas_busy_i,
  input wire logic rf_sending_i,
  // mode and processor control
  output logic run_mode_o,
  output logic debug_halt_o,
  output logic cpu_suspend_o,
  output logic fetch_vector_o,
  output logic [15:0] fetch_addr_o,
  output logic illegal_op_reset_o,
  output logic module_reset_o,
  output logic ram_lost_o,
  // command answers
  output logic cmd_accept_o,
  output logic cmd_reject_o,
  // power and clock control
  output logic deep_stop_o,
  output logic light_stop_o,
  output logic sys_clk_en_o,
  output logic debug_clk_en_o,
  output logic fast_osc_en_o,
  output logic slow_osc_en_o,
  output logic always_on_pwr_o,
  output logic regulator_on_o,
  output logic mem_standby_o,
  output logic pins_hold_o,
  output logic pins_hiz_o,
  output logic lvd_armed_o,
  output logic lvd_irq_o,
  output logic lvd_reset_o,
  output logic medium_osc_en_o,
  output logic lfr_det_pwr_o,
  output logic periodic_tick_flag_o
);

  omc_state_e state_q, state_d;
  logic bg_s1_q, bg_s2_q;
  logic deep_ok, light_go, halt_req, nonintr, halted_cmd;

  // strap pin is asynchronous; two stages before use
  // no reset: the stages track the pin during reset, so release sees the real strap
  always_ff @(posedge ref_clk_i) begin
    bg_s1_q <= background_pin_i;
    bg_s2_q <= bg_s1_q;
  end

  assign halt_req = halt_cmd_i | enter_debug_instr_i | breakpoint_i;
  // a pending interrupt, in-stop detector or debug enable keeps the regulator up
  assign deep_ok = (power_mode_control_2_i == OMC_SEL_DEEP) && !irq_pending_i &&
                   !(lowvolt_detect_enable_i && lowvolt_in_stop_enable_i) &&
                   !debug_enable_i; // RULE12 RULE14 RULE20
  // second stop mode does not exist; legacy third mode behaves as light stop
  assign light_go = (power_mode_control_2_i != OMC_SEL_SECOND) || debug_enable_i; // RULE8

  // mode sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      OMC_ST_RESET: begin
        state_d = bg_s2_q ? OMC_ST_RUN : OMC_ST_HALT; // RULE1 RULE2
      end
      OMC_ST_RUN: begin
        if (halt_req) begin
          state_d = OMC_ST_HALT; // RULE2
        end else if (stop_instr_i && stop_enable_i) begin
          if (deep_ok) begin
            state_d = OMC_ST_DEEP; // RULE9
          end else if (light_go) begin
            state_d = OMC_ST_LIGHT; // RULE14 RULE15
          end
        end else if (stop_instr_i) begin
          state_d = OMC_ST_RESET; // RULE6
        end
      end
      OMC_ST_HALT: begin
        if (cmd_valid_i && cmd_class_i == OMC_CMD_GO) begin
          state_d = OMC_ST_RUN; // RULE5
        end
      end
      OMC_ST_DEEP: begin
        // wake is a restart, held until supply is re-armed
        if (ext_wake_i && supply_rearmed_i) begin
          state_d = OMC_ST_RESET; // RULE9 RULE10 RULE11
        end
      end
      OMC_ST_LIGHT: begin
        if (halt_cmd_i && debug_enable_i) begin
          state_d = OMC_ST_HALT;
        end else if (ext_wake_i) begin
          state_d = OMC_ST_RUN;
        end
      end
      default: state_d = OMC_ST_RESET;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      state_q <= OMC_ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // command classes gated by mode
  assign nonintr = (cmd_class_i == OMC_CMD_MEM) || (cmd_class_i == OMC_CMD_MEM_STAT) ||
                   (cmd_class_i == OMC_CMD_DBG_REG) || (cmd_class_i == OMC_CMD_HALT);
  assign halted_cmd = (cmd_class_i == OMC_CMD_CPU_REG) || (cmd_class_i == OMC_CMD_TRACE) ||
                      (cmd_class_i == OMC_CMD_GO);

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      cmd_accept_o <= 1'b0;
      cmd_reject_o <= 1'b0;
    end else begin
      cmd_accept_o <= cmd_valid_i && ((nonintr && (state_q == OMC_ST_RUN ||
                      state_q == OMC_ST_HALT)) ||
                      (halted_cmd && state_q == OMC_ST_HALT)); // RULE4 RULE5
      cmd_reject_o <= cmd_valid_i && !((nonintr && (state_q == OMC_ST_RUN ||
                      state_q == OMC_ST_HALT)) ||
                      (halted_cmd && state_q == OMC_ST_HALT));
    end
  end

  // processor and mode outputs, registered from the next state
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      run_mode_o <= 1'b0;
      debug_halt_o <= 1'b0;
      cpu_suspend_o <= 1'b1;
      fetch_vector_o <= 1'b0;
      fetch_addr_o <= OMC_RESET_VEC_HI;
      illegal_op_reset_o <= 1'b0;
      module_reset_o <= 1'b1;
      ram_lost_o <= 1'b1;
    end else begin
      run_mode_o <= state_d == OMC_ST_RUN;
      debug_halt_o <= state_d == OMC_ST_HALT;
      cpu_suspend_o <= state_d != OMC_ST_RUN; // RULE3
      // vector fetch only on the restart into run
      fetch_vector_o <= state_q == OMC_ST_RESET && state_d == OMC_ST_RUN; // RULE1 RULE11
      fetch_addr_o <= OMC_RESET_VEC_HI;
      illegal_op_reset_o <= state_q == OMC_ST_RUN && stop_instr_i && !stop_enable_i &&
                            !halt_req; // RULE6
      module_reset_o <= state_q == OMC_ST_DEEP && state_d == OMC_ST_RESET; // RULE21
      if (state_q == OMC_ST_DEEP && state_d == OMC_ST_RESET) begin
        ram_lost_o <= 1'b1; // RULE21
      end else if (state_d == OMC_ST_RUN) begin
        ram_lost_o <= 1'b0;
      end
    end
  end

  // power and clock gating per mode
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      deep_stop_o <= 1'b0;
      light_stop_o <= 1'b0;
      sys_clk_en_o <= 1'b1;
      debug_clk_en_o <= 1'b1;
      fast_osc_en_o <= 1'b1;
      slow_osc_en_o <= 1'b1;
      always_on_pwr_o <= 1'b1;
      regulator_on_o <= 1'b1;
      mem_standby_o <= 1'b0;
      pins_hold_o <= 1'b0;
      pins_hiz_o <= 1'b0;
      lvd_armed_o <= 1'b0;
    end else begin
      deep_stop_o <= state_d == OMC_ST_DEEP;
      light_stop_o <= state_d == OMC_ST_LIGHT;
      // system clock and fast oscillator stop in both stop modes; the slow oscillator keeps running
      sys_clk_en_o <= state_d != OMC_ST_DEEP && state_d != OMC_ST_LIGHT; // RULE7
      fast_osc_en_o <= state_d != OMC_ST_DEEP && state_d != OMC_ST_LIGHT; // RULE7
      debug_clk_en_o <= (state_d != OMC_ST_DEEP && state_d != OMC_ST_LIGHT) ||
                        debug_enable_i; // RULE20
      slow_osc_en_o <= 1'b1; // RULE7 RULE18
      always_on_pwr_o <= 1'b1; // RULE18
      regulator_on_o <= state_d != OMC_ST_DEEP; // RULE9 RULE14 RULE15
      mem_standby_o <= state_d == OMC_ST_LIGHT; // RULE15
      pins_hold_o <= state_d == OMC_ST_LIGHT; // RULE15
      pins_hiz_o <= state_d == OMC_ST_DEEP;
      lvd_armed_o <= state_d == OMC_ST_DEEP ||
                     (lowvolt_detect_enable_i && state_d != OMC_ST_RESET); // RULE10
    end
  end

  // low-voltage trip, oscillator requests and periodic tick
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      lvd_irq_o <= 1'b0;
      lvd_reset_o <= 1'b0;
      medium_osc_en_o <= 1'b0;
      lfr_det_pwr_o <= 1'b0;
      periodic_tick_flag_o <= 1'b0;
    end else begin
      lvd_irq_o <= lvd_armed_o && supply_low_i && !lowvolt_reset_enable_i; // RULE13
      lvd_reset_o <= lvd_armed_o && supply_low_i && lowvolt_reset_enable_i; // RULE13
      medium_osc_en_o <= lfr_sampling_i || lfr_detect_i || meas_busy_i ||
                         rf_sending_i; // RULE17 RULE19
      lfr_det_pwr_o <= lfr_sampling_i || lfr_detect_i; // RULE19
      // set wins over clear; cleared as deep stop starts, never flags inside it
      if (tick_event_i && state_q != OMC_ST_DEEP && state_d != OMC_ST_DEEP &&
          (tick_on_slow_osc_i || state_q == OMC_ST_RUN)) begin
        periodic_tick_flag_o <= 1'b1; // RULE16
      end else if (state_d == OMC_ST_DEEP || state_d == OMC_ST_RESET) begin
        periodic_tick_flag_o <= 1'b0;
      end
    end
  end

  // checks
  sequence s_deep_req;
    state_q == OMC_ST_RUN && stop_instr_i && stop_enable_i && !halt_req;
  endsequence
  property p_strap_run;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      state_q == OMC_ST_RESET && bg_s2_q |=> run_mode_o && fetch_vector_o;
  endproperty
  a_strap_run: assert property (p_strap_run) else $error("no run after strap high"); // RULE1
  property p_halt;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      state_q == OMC_ST_RUN && halt_req |=> debug_halt_o && cpu_suspend_o;
  endproperty
  a_halt: assert property (p_halt) else $error("halt request ignored"); // RULE2
  property p_gated;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      cmd_valid_i && halted_cmd && state_q != OMC_ST_HALT |=> !cmd_accept_o;
  endproperty
  a_gated: assert property (p_gated) else $error("halted command ran"); // RULE5
  property p_illegal;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      state_q == OMC_ST_RUN && stop_instr_i && !stop_enable_i && !halt_req
      |=> illegal_op_reset_o && !run_mode_o;
  endproperty
  a_illegal: assert property (p_illegal) else $error("no illegal-op reset"); // RULE6
  property p_block_deep;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      s_deep_req and (irq_pending_i || debug_enable_i) |=> !deep_stop_o;
  endproperty
  a_block_deep: assert property (p_block_deep) else $error("deep stop not blocked"); // RULE12
  property p_deep_power;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      deep_stop_o |-> !regulator_on_o && !sys_clk_en_o && slow_osc_en_o && lvd_armed_o;
  endproperty
  a_deep_power: assert property (p_deep_power) else $error("deep stop power wrong"); // RULE10
  property p_light;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      light_stop_o |-> regulator_on_o && pins_hold_o && mem_standby_o;
  endproperty
  a_light: assert property (p_light) else $error("light stop power wrong"); // RULE15
  property p_wake;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      state_q == OMC_ST_DEEP && ext_wake_i && !supply_rearmed_i |=> deep_stop_o;
  endproperty
  a_wake: assert property (p_wake) else $error("left deep stop unarmed"); // RULE10
  property p_tick;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      state_q == OMC_ST_DEEP |=> !periodic_tick_flag_o;
  endproperty
  a_tick: assert property (p_tick) else $error("tick flag in deep stop"); // RULE16
  property p_mfo;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      meas_busy_i || rf_sending_i |=> medium_osc_en_o;
  endproperty
  a_mfo: assert property (p_mfo) else $error("medium osc off"); // RULE17
  sequence s_deep_wake;
    state_q == OMC_ST_DEEP && ext_wake_i && supply_rearmed_i;
  endsequence
  property p_nonintr;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      cmd_valid_i && nonintr && (state_q == OMC_ST_RUN || state_q == OMC_ST_HALT)
      |=> cmd_accept_o && !cmd_reject_o;
  endproperty
  a_nonintr: assert property (p_nonintr) else $error("command refused"); // RULE4
  property p_go;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      state_q == OMC_ST_HALT && cmd_valid_i && cmd_class_i == OMC_CMD_GO
      |=> run_mode_o && cmd_accept_o && !cpu_suspend_o;
  endproperty
  a_go: assert property (p_go) else $error("go did not resume"); // RULE5
  property p_redirect;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      s_deep_req and (power_mode_control_2_i == OMC_SEL_DEEP && lowvolt_detect_enable_i &&
      lowvolt_in_stop_enable_i) |=> light_stop_o && regulator_on_o;
  endproperty
  a_redirect: assert property (p_redirect) else $error("deep not redirected"); // RULE14
  property p_second;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      s_deep_req and (power_mode_control_2_i == OMC_SEL_SECOND && !debug_enable_i)
      |=> run_mode_o && !deep_stop_o && !light_stop_o;
  endproperty
  a_second: assert property (p_second) else $error("second stop mode entered"); // RULE8
  property p_restart;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      s_deep_wake |=> module_reset_o && ram_lost_o && cpu_suspend_o
      ##1 (run_mode_o || debug_halt_o);
  endproperty
  a_restart: assert property (p_restart) else $error("deep wake not a restart"); // RULE11

endmodule // omc_mode_ctrl

// ### omc_debug_host.sv
`timescale 1ns/1ns
// debug host on the background pin; every command is a one-cycle strobe
module omc_debug_host (
  // clock and device mode
  input wire logic ref_clk_i,
  input wire logic debug_halt_i,
  // strap and command strobes
  output logic background_pin_o,
  output logic halt_cmd_o,
  output logic cmd_valid_o,
  output logic [2:0] cmd_class_o
);
  // idle pin sits at its pull-up level
  initial begin
    background_pin_o = 1'b1;
    halt_cmd_o = 1'b0;
    cmd_valid_o = 1'b0;
    cmd_class_o = 3'h7;
  end
  // strap must stay put across reset release
  task automatic strap(input logic lvl);
    background_pin_o <= lvl;
  endtask
  // halt command
  task automatic halt();
    @(posedge ref_clk_i);
    halt_cmd_o <= 1'b1;
    @(posedge ref_clk_i);
    halt_cmd_o <= 1'b0;
  endtask
  // intrusive classes only while halted, unless told to misbehave
  task automatic send(input logic [2:0] cls, input logic rude);
    if (cls < 3'h4 || debug_halt_i || rude) begin
      @(posedge ref_clk_i);
      cmd_valid_o <= 1'b1;
      cmd_class_o <= cls;
      @(posedge ref_clk_i);
      cmd_valid_o <= 1'b0;
      cmd_class_o <= ~cls; // released lines must not keep the last value
    end
  endtask
endmodule // omc_debug_host

// ### operating_mode_controller_tb.sv
`timescale 1ns/1ns
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module operating_mode_controller_tb import omc_pkg::*;;
  // stimulus and observed signals
  logic ref_clk_i = 1'b0;
  logic rstn_i, enter_debug_instr_i, breakpoint_i, stop_instr_i, stop_enable_i;
  logic [1:0] power_mode_control_2_i;
  logic lowvolt_detect_enable_i, lowvolt_in_stop_enable_i, lowvolt_reset_enable_i;
  logic debug_enable_i, irq_pending_i, ext_wake_i, supply_low_i, supply_rearmed_i;
  logic tick_event_i, tick_on_slow_osc_i, lfr_sampling_i, lfr_detect_i, meas_busy_i;
  logic rf_sending_i, background_pin_i, halt_cmd_i, cmd_valid_i;
  logic [2:0] cmd_class_i;
  logic run_mode_o, debug_halt_o, cpu_suspend_o, fetch_vector_o, illegal_op_reset_o;
  logic module_reset_o, ram_lost_o, cmd_accept_o, cmd_reject_o, deep_stop_o, light_stop_o;
  logic sys_clk_en_o, debug_clk_en_o, fast_osc_en_o, slow_osc_en_o, always_on_pwr_o;
  logic regulator_on_o, mem_standby_o, pins_hold_o, pins_hiz_o, lvd_armed_o, lvd_irq_o;
  logic lvd_reset_o, medium_osc_en_o, lfr_det_pwr_o, periodic_tick_flag_o;
  logic [15:0] fetch_addr_o;
  int failures = 0;
  int cmp_count = 0;
  // 100 MHz clock
  always #5 ref_clk_i = ~ref_clk_i;
  omc_mode_ctrl u_omc_mode_ctrl (.ref_clk_i, .rstn_i, .background_pin_i, .halt_cmd_i,
    .enter_debug_instr_i, .breakpoint_i, .cmd_valid_i, .cmd_class_i, .stop_instr_i,
    .stop_enable_i, .power_mode_control_2_i, .lowvolt_detect_enable_i,
    .lowvolt_in_stop_enable_i, .lowvolt_reset_enable_i, .debug_enable_i, .irq_pending_i,
    .ext_wake_i, .supply_low_i, .supply_rearmed_i, .tick_event_i, .tick_on_slow_osc_i,
    .lfr_sampling_i, .lfr_detect_i, .meas_busy_i, .rf_sending_i, .run_mode_o, .debug_halt_o,
    .cpu_suspend_o, .fetch_vector_o, .fetch_addr_o, .illegal_op_reset_o, .module_reset_o,
    .ram_lost_o, .cmd_accept_o, .cmd_reject_o, .deep_stop_o, .light_stop_o, .sys_clk_en_o,
    .debug_clk_en_o, .fast_osc_en_o, .slow_osc_en_o, .always_on_pwr_o, .regulator_on_o,
    .mem_standby_o, .pins_hold_o, .pins_hiz_o, .lvd_armed_o, .lvd_irq_o, .lvd_reset_o,
    .medium_osc_en_o, .lfr_det_pwr_o, .periodic_tick_flag_o);
  omc_debug_host u_omc_debug_host (.ref_clk_i, .debug_halt_i(debug_halt_o),
    .background_pin_o(background_pin_i), .halt_cmd_o(halt_cmd_i),
    .cmd_valid_o(cmd_valid_i), .cmd_class_o(cmd_class_i));
  // settle past the edge so registered outputs have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic stop(input logic [1:0] sel, input logic en);
    @(posedge ref_clk_i);
    power_mode_control_2_i <= sel;
    stop_enable_i <= en;
    stop_instr_i <= 1'b1;
    @(posedge ref_clk_i);
    stop_instr_i <= 1'b0;
    #1;
  endtask
  task automatic wake();
    @(posedge ref_clk_i);
    ext_wake_i <= 1'b1;
    @(posedge ref_clk_i);
    ext_wake_i <= 1'b0;
    cyc(1);
  endtask
  // reset with the strap at a chosen level
  task automatic t_reset(input logic strap);
    @(posedge ref_clk_i);
    rstn_i <= 1'b0;
    u_omc_debug_host.strap(strap);
    cyc(5);
    @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    cyc(1);
    `CHK(run_mode_o, strap)
    `CHK(debug_halt_o, ~strap)
    `CHK(cpu_suspend_o, ~strap)
    if (strap) `CHK(fetch_vector_o, 1'b1)
    `CHK(fetch_addr_o, OMC_RESET_VEC_HI)
    `CHK({slow_osc_en_o, always_on_pwr_o}, 2'h3)
  endtask
  // all classes but halt in run from a misbehaving host, then all in halt
  task automatic t_cmds();
    for (int c = 0; c < 7; c++) begin
      if (c != 3) begin
        u_omc_debug_host.send(3'(c), 1'b1);
        #1;
        `CHK({cmd_accept_o, cmd_reject_o}, {c < 4, c >= 4})
      end
    end
    u_omc_debug_host.halt();
    cyc(1);
    for (int c = 0; c < 7; c++) begin
      u_omc_debug_host.send(3'(c), 1'b0);
      #1;
      `CHK({cmd_accept_o, cmd_reject_o}, 2'h2)
    end
    cyc(1);
    `CHK(run_mode_o, 1'b1)
  endtask
  // each halt source, resumed by the go command
  task automatic t_halt_src();
    for (int s = 0; s < 3; s++) begin
      if (s == 0) u_omc_debug_host.halt();
      else begin
        @(posedge ref_clk_i);
        enter_debug_instr_i <= (s == 1);
        breakpoint_i <= (s == 2);
        @(posedge ref_clk_i);
        {enter_debug_instr_i, breakpoint_i} <= 2'h0;
      end
      cyc(1);
      `CHK({debug_halt_o, cpu_suspend_o, run_mode_o}, 3'h6)
      u_omc_debug_host.send(OMC_CMD_GO, 1'b0);
      cyc(1);
      `CHK(run_mode_o, 1'b1)
    end
  endtask
  // deep request turned into light stop, plus plain light and legacy selects
  task automatic t_light();
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk_i);
      {lowvolt_detect_enable_i, lowvolt_in_stop_enable_i} <= {2{k == 0}};
      debug_enable_i <= (k == 1);
      tick_on_slow_osc_i <= 1'b1;
      stop(k < 2 ? OMC_SEL_DEEP : (k == 2 ? OMC_SEL_LEGACY3 : OMC_SEL_LIGHT), 1'b1);
      `CHK({light_stop_o, deep_stop_o, regulator_on_o}, 3'h5)
      `CHK({mem_standby_o, pins_hold_o, pins_hiz_o}, 3'h6)
      `CHK(debug_clk_en_o, k == 1)
      `CHK(sys_clk_en_o, 1'b0)
      @(posedge ref_clk_i);
      tick_event_i <= 1'b1;
      @(posedge ref_clk_i);
      tick_event_i <= 1'b0;
      #1;
      `CHK(periodic_tick_flag_o, 1'b1)
      if (k == 1) begin
        u_omc_debug_host.halt();
        cyc(1);
        `CHK({debug_halt_o, light_stop_o}, 2'h2)
        u_omc_debug_host.send(OMC_CMD_GO, 1'b0);
      end
      wake();
      `CHK(run_mode_o, 1'b1)
    end
    @(posedge ref_clk_i);
    {lowvolt_detect_enable_i, lowvolt_in_stop_enable_i, debug_enable_i} <= 3'h0;
  endtask
  // deep stop: sleeps through tick, halt and unarmed wake, then restarts
  task automatic t_deep();
    stop(OMC_SEL_DEEP, 1'b1);
    `CHK({deep_stop_o, run_mode_o, regulator_on_o, pins_hiz_o}, 4'h9)
    `CHK({sys_clk_en_o, fast_osc_en_o, slow_osc_en_o}, 3'h1)
    `CHK({lvd_armed_o, periodic_tick_flag_o}, 2'h2)
    @(posedge ref_clk_i);
    tick_event_i <= 1'b1;
    ext_wake_i <= 1'b1;
    @(posedge ref_clk_i);
    tick_event_i <= 1'b0;
    u_omc_debug_host.halt();
    cyc(2);
    `CHK({deep_stop_o, debug_halt_o, periodic_tick_flag_o}, 3'h4)
    @(posedge ref_clk_i);
    supply_rearmed_i <= 1'b1;
    cyc(1);
    `CHK({module_reset_o, ram_lost_o, cpu_suspend_o}, 3'h7)
    cyc(1);
    `CHK({run_mode_o, fetch_vector_o}, 2'h3)
    @(posedge ref_clk_i);
    {ext_wake_i, supply_rearmed_i} <= 2'h0;
  endtask
  // refused stops, low-voltage events and oscillator demand
  task automatic t_misc();
    stop(OMC_SEL_DEEP, 1'b0);
    `CHK({illegal_op_reset_o, run_mode_o, deep_stop_o}, 3'h4)
    cyc(1);
    `CHK(run_mode_o, 1'b1)
    @(posedge ref_clk_i);
    irq_pending_i <= 1'b1;
    stop(OMC_SEL_DEEP, 1'b1);
    `CHK(deep_stop_o, 1'b0)
    irq_pending_i <= 1'b0;
    wake();
    stop(OMC_SEL_SECOND, 1'b1);
    `CHK({run_mode_o, deep_stop_o, light_stop_o}, 3'h4)
    for (int r = 0; r < 2; r++) begin
      @(posedge ref_clk_i);
      lowvolt_detect_enable_i <= 1'b1;
      lowvolt_reset_enable_i <= (r == 1);
      cyc(2);
      @(posedge ref_clk_i);
      supply_low_i <= 1'b1;
      @(posedge ref_clk_i);
      supply_low_i <= 1'b0;
      #1;
      `CHK({lvd_armed_o, lvd_irq_o | lvd_reset_o, lvd_reset_o}, {2'h3, r == 1})
    end
    t_reset(1'b1);
    lowvolt_detect_enable_i <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      @(posedge ref_clk_i);
      {lfr_sampling_i, lfr_detect_i, meas_busy_i, rf_sending_i} <= 4'h8 >> s;
      cyc(2);
      `CHK(medium_osc_en_o, 1'b1)
    end
    lfr_sampling_i <= 1'b1;
    stop(OMC_SEL_DEEP, 1'b1);
    cyc(1);
    `CHK({deep_stop_o, lfr_det_pwr_o, medium_osc_en_o}, 3'h7)
  endtask
  task automatic finish_test();
    $display("compares=%0d failures=%0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // main sequence; a reset ends the final deep stop
  initial begin
    {rstn_i, enter_debug_instr_i, breakpoint_i, stop_instr_i, power_mode_control_2_i} = '0;
    {lowvolt_detect_enable_i, lowvolt_in_stop_enable_i, lowvolt_reset_enable_i} = '0;
    {debug_enable_i, irq_pending_i, ext_wake_i, supply_low_i, supply_rearmed_i} = '0;
    {tick_event_i, tick_on_slow_osc_i, lfr_sampling_i, lfr_detect_i} = '0;
    {meas_busy_i, rf_sending_i} = '0;
    stop_enable_i = 1'b1;
    t_reset(1'b0);
    t_reset(1'b1);
    t_cmds();
    t_halt_src();
    t_light();
    t_deep();
    t_misc();
    t_reset(1'b1);
    finish_test();
  end
  // hang guard, far beyond the roughly 170 cycles the sequence needs
  initial begin
    #50000;
    failures++;
    finish_test();
  end
endmodule // operating_mode_controller_tb
